// file: mtr_pkg.sv
// constants and types shared by the trigger router files
`default_nettype none
package mtr_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS   = 100;
  localparam int RATE_STEP_NS    = 200;
  localparam int RATE_STEP_CYC   = (RATE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RATE_MAX_S      = 10000;
  localparam int RATE_W          = 36;
  localparam int EXT_LAT_PERIODS = 7;
  localparam int LOCK_MARKS      = 2;
  // master clock output figures in kHz
  localparam logic [16:0] PA_CLK_KHZ   = 17'h0C350;
  localparam logic [16:0] MANT_X4_LIM  = 17'h030D4;
  localparam logic [16:0] MANT_X2_LIM  = 17'h061A8;
  localparam logic [16:0] MANT_X1_LIM  = 17'h0C350;
  // register offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_RATE_LO = 8'h04;
  localparam logic [7:0] OFS_RATE_HI = 8'h08;
  localparam logic [7:0] OFS_MANT    = 8'h0C;
  localparam logic [7:0] OFS_CMD     = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h18;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h1C;
  // control register fields
  localparam int CTRL_W      = 25;
  localparam int F_TRIG_SRC  = 0;
  localparam int F_TO_START  = 3;
  localparam int F_TO_ADV    = 4;
  localparam int F_CLK_SRC   = 5;
  localparam int F_SYS_CH    = 7;
  localparam int F_CHAIN_EN  = 9;
  localparam int F_RING_EN   = 10;
  localparam int F_PHASE_ACC = 11;
  localparam int F_ADV_EVENT = 12;
  localparam int F_ADV_SYNC  = 13;
  localparam int F_BP_SRC    = 14;
  localparam int F_LOOP_ALL  = 17;
  localparam int F_LOOP_MSK  = 18;
  localparam int F_RATE_EN   = 22;
  localparam int F_SEG_LAST  = 23;
  localparam logic [CTRL_W-1:0] CTRL_RST = 25'h0800000;
  // command register bits
  localparam int CMD_SYS   = 0;
  localparam int CMD_CHAN  = 1;
  localparam int CMD_PHASE = 2;
  // trigger sources
  localparam logic [2:0] TS_SYS    = 3'h0;
  localparam logic [2:0] TS_PIN    = 3'h1;
  localparam logic [2:0] TS_RATE   = 3'h2;
  localparam logic [2:0] TS_CMD    = 3'h3;
  localparam logic [2:0] TS_MASTER = 3'h4;
  localparam logic [2:0] TS_PREV   = 3'h5;
  localparam int NUM_TS = 6;
  // backplane sources
  localparam logic [2:0] BP_TRACE = 3'h0;
  localparam logic [2:0] BP_BURST = 3'h1;
  localparam logic [2:0] BP_LOOP  = 3'h2;
  localparam logic [2:0] BP_COUNT = 3'h3;
  localparam logic [2:0] BP_WAVE  = 3'h4;
  localparam logic [2:0] BP_TRIG  = 3'h5;
  localparam int NUM_BP = 6;
  // sample clock sources
  localparam logic [1:0] CLK_OWN = 2'h0;
  localparam logic [1:0] CLK_EXT = 2'h1;
  localparam logic [1:0] CLK_SYS = 2'h2;
  // pin indices into the synchroniser
  localparam int PIN_SYS  = 0;
  localparam int PIN_MAN  = 1;
  localparam int PIN_CHAN = 2;
  localparam int PIN_MAST = 3;
  localparam int PIN_BP   = 4;
  localparam int PIN_EXT  = 5;
  localparam int NUM_PIN  = 6;
  // interrupt events
  localparam int EV_START = 0;
  localparam int EV_ADV   = 1;
  localparam int EV_BP    = 2;
  localparam int EV_LOCK  = 3;
  localparam int NUM_EV   = 4;
  typedef enum logic [1:0] {
    MTR_IDLE = 2'b01,
    MTR_RUN  = 2'b10
  } mtr_seq_t;
endpackage : mtr_pkg
`default_nettype wire

// file: mtr_sync.sv
// three-stage pin synchroniser with agreement filter and rising-edge pulse
`default_nettype none
module mtr_sync #(
  parameter int N = 6
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  // raw pins
  input  wire logic [N-1:0] pin_in,
  // filtered level and one-cycle rise
  output logic      [N-1:0] level,
  output logic      [N-1:0] rise
);
  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] filt;
    logic [N-1:0] rise;
  } mtr_sync_st_t;

  mtr_sync_st_t st_r;
  mtr_sync_st_t st_nxt;
  logic [N-1:0] agree;

  // s1 feeds s2 only; decisions look at s2 and s3
  assign agree = ~(st_r.s2 ^ st_r.s3);

  always_comb
  begin
    st_nxt = st_r;
    if (ce)
    begin
      st_nxt.s1   = pin_in;
      st_nxt.s2   = st_r.s1;
      st_nxt.s3   = st_r.s2;
      st_nxt.filt = (agree & st_r.s3) | (~agree & st_r.filt);
      st_nxt.rise = st_nxt.filt & ~st_r.filt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign level = st_r.filt;
  assign rise  = st_r.rise;
endmodule : mtr_sync
`default_nettype wire

// file: mtr_channel.sv
// one channel of the multichannel trigger router
// Function
// - trigger picked from system, pin, rate gen, command, master or previous channel
// - rate generator period 200 ns to 10,000 s in 200 ns steps
// - master trigger comes from channel 1 rate generator, usable everywhere
// - chain out: count complete, loop complete any/all, waveform complete
// - start trigger begins gated/triggered output and launches the sequence
// - advance trigger moves the sequence to the next segment
// - external clock: start latency seven sample periods plus under 100 ns (code adds four to five 100 ns ref_clk cycles after the seventh edge)
// - take trigger from previous channel, drive own source to next
// - last channel may drive its source back to the first
// - each channel configured on its own
// - chain sources include trace end, burst complete, loop complete
// - phase lock regained one full waveform cycle after phase change
// - sample clock from own generator, external input or system clock
// - phase accumulate mode fixes clock output at 50 MHz
// - raster mode clock output 25 to 50 MHz following mantissa (code leaves mantissas below 6250 or above 100001 kHz outside the band)
// - event advance latched on rising edge, level advance unlatched
// - synchronous advance waits segment end, asynchronous goes at once
//
// The strobed register port and the address map are this design's own decisions.
`default_nettype none
module mtr_channel (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rd_data,
  // trigger pins
  input  wire logic        sys_trig_pin,
  input  wire logic        manual_key,
  input  wire logic        chan_trig_pin,
  input  wire logic        master_trig_in,
  input  wire logic        bp_trig_in,
  input  wire logic        ext_clk_in,
  // waveform engine events
  input  wire logic        trace_end,
  input  wire logic        burst_done,
  input  wire logic        count_done,
  input  wire logic        wave_done,
  input  wire logic [3:0]  seg_loop_done,
  input  wire logic        seg_end,
  // trigger results
  output logic             start_trig,
  output logic             adv_trig,
  output logic      [1:0]  seg_idx,
  output logic             gate_run,
  output logic             bp_trig_out,
  output logic             ring_trig_out,
  output logic             rate_trig,
  // clocking
  output logic             phase_lock,
  output logic      [1:0]  clk_src_sel,
  output logic      [1:0]  sys_clk_ch,
  output logic      [16:0] clk_out_khz,
  // interrupt
  output logic             irq
);
  typedef struct packed {
    logic [mtr_pkg::CTRL_W-1:0] ctrl;
    logic [mtr_pkg::RATE_W-1:0] rate;
    logic [16:0]                mant;
    logic [mtr_pkg::NUM_EV-1:0] msk;
    logic [mtr_pkg::NUM_EV-1:0] ist;
    logic [1:0]                 pre;
    logic [mtr_pkg::RATE_W-1:0] step;
    mtr_pkg::mtr_seq_t          seq;
    logic [1:0]                 seg;
    logic                       adv_lat;
    logic [3:0]                 loop_seen;
    logic                       lat_pend;
    logic [2:0]                 lat_cnt;
    logic                       lock;
    logic [1:0]                 lock_cnt;
    logic                       start;
    logic                       adv;
    logic                       gate;
    logic                       bp_out;
    logic                       ring_out;
    logic                       rate_p;
    logic [16:0]                clk_khz;
    logic [31:0]                rd;
    logic                       irq;
  } mtr_ch_st_t;

  mtr_ch_st_t st_r;
  mtr_ch_st_t st_nxt;

  logic [mtr_pkg::NUM_PIN-1:0] pin_lvl;
  logic [mtr_pkg::NUM_PIN-1:0] pin_rise;

  mtr_sync #(
    .N (mtr_pkg::NUM_PIN)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .pin_in  ({ext_clk_in, bp_trig_in, master_trig_in,
               chan_trig_pin, manual_key, sys_trig_pin}),
    .level   (pin_lvl),
    .rise    (pin_rise)
  );

  // control fields
  logic [2:0]  trig_src;
  logic [2:0]  bp_src;
  logic [1:0]  clk_src;
  logic [1:0]  seg_last;
  logic [3:0]  loop_msk;
  logic        to_start;
  logic        to_adv;
  logic        chain_en;
  logic        ring_en;
  logic        phase_acc_mode;
  logic        adv_event;
  logic        adv_sync;
  logic        loop_all;
  logic        rate_en;

  assign trig_src       = st_r.ctrl[mtr_pkg::F_TRIG_SRC +: 3];
  assign to_start       = st_r.ctrl[mtr_pkg::F_TO_START];
  assign to_adv         = st_r.ctrl[mtr_pkg::F_TO_ADV];
  assign clk_src        = st_r.ctrl[mtr_pkg::F_CLK_SRC +: 2];
  assign chain_en       = st_r.ctrl[mtr_pkg::F_CHAIN_EN];
  assign ring_en        = st_r.ctrl[mtr_pkg::F_RING_EN];
  assign phase_acc_mode = st_r.ctrl[mtr_pkg::F_PHASE_ACC];
  assign adv_event      = st_r.ctrl[mtr_pkg::F_ADV_EVENT];
  assign adv_sync       = st_r.ctrl[mtr_pkg::F_ADV_SYNC];
  assign bp_src         = st_r.ctrl[mtr_pkg::F_BP_SRC +: 3];
  assign loop_all       = st_r.ctrl[mtr_pkg::F_LOOP_ALL];
  assign loop_msk       = st_r.ctrl[mtr_pkg::F_LOOP_MSK +: 4];
  assign rate_en        = st_r.ctrl[mtr_pkg::F_RATE_EN];
  assign seg_last       = st_r.ctrl[mtr_pkg::F_SEG_LAST +: 2];

  // register strobes
  logic wr_ctrl;
  logic wr_cmd;
  logic cmd_sys;
  logic cmd_chan;
  logic cmd_phase;

  assign wr_ctrl   = wr_en && (addr == mtr_pkg::OFS_CTRL);
  assign wr_cmd    = wr_en && (addr == mtr_pkg::OFS_CMD);
  assign cmd_sys   = wr_cmd && wr_data[mtr_pkg::CMD_SYS];
  assign cmd_chan  = wr_cmd && wr_data[mtr_pkg::CMD_CHAN];
  assign cmd_phase = wr_cmd && wr_data[mtr_pkg::CMD_PHASE];

  // trigger source selection, pulse and level views
  logic [mtr_pkg::NUM_TS-1:0] ts_pulse;
  logic [mtr_pkg::NUM_TS-1:0] ts_level;
  logic                       trig_p;
  logic                       trig_l;

  assign ts_pulse = {pin_rise[mtr_pkg::PIN_BP], pin_rise[mtr_pkg::PIN_MAST], cmd_chan,
                     st_r.rate_p, pin_rise[mtr_pkg::PIN_CHAN],
                     pin_rise[mtr_pkg::PIN_SYS] | pin_rise[mtr_pkg::PIN_MAN] | cmd_sys};
  assign ts_level = {pin_lvl[mtr_pkg::PIN_BP], pin_lvl[mtr_pkg::PIN_MAST], cmd_chan,
                     st_r.rate_p, pin_lvl[mtr_pkg::PIN_CHAN],
                     pin_lvl[mtr_pkg::PIN_SYS] | pin_lvl[mtr_pkg::PIN_MAN] | cmd_sys};
  // previous channel and master only arrive through the synchroniser
  assign trig_p = (trig_src < 3'(mtr_pkg::NUM_TS)) ? ts_pulse[trig_src] : 1'b0;
  assign trig_l = (trig_src < 3'(mtr_pkg::NUM_TS)) ? ts_level[trig_src] : 1'b0;

  // loop complete from any or all selected segments
  logic [3:0] loop_hit;
  logic [3:0] loop_acc;
  logic       loop_ev;

  assign loop_hit = seg_loop_done & loop_msk;
  assign loop_acc = st_r.loop_seen | loop_hit;
  assign loop_ev  = loop_all ? ((|loop_hit) && (loop_msk != 4'h0) && (loop_acc == loop_msk))
                             : (|loop_hit);

  // backplane source selection
  logic [mtr_pkg::NUM_BP-1:0] bp_vec;
  logic                       bp_p;

  assign bp_vec = {trig_p, wave_done, count_done, loop_ev, burst_done, trace_end};
  assign bp_p   = (bp_src < 3'(mtr_pkg::NUM_BP)) ? bp_vec[bp_src] : 1'b0;

  // rate generator period in steps; zero acts as one step
  logic [mtr_pkg::RATE_W-1:0] period_m1;

  assign period_m1 = (st_r.rate == '0) ? '0 : st_r.rate - mtr_pkg::RATE_W'(1);

  // raster mantissa folded into the 25 to 50 MHz band for mantissas 6250 to 100001 kHz
  logic [16:0] raster_khz;

  assign raster_khz = (st_r.mant < mtr_pkg::MANT_X4_LIM) ? {st_r.mant[14:0], 2'b00} :
                      (st_r.mant < mtr_pkg::MANT_X2_LIM) ? {st_r.mant[15:0], 1'b0}  :
                      (st_r.mant < mtr_pkg::MANT_X1_LIM) ? st_r.mant :
                                                           {1'b0, st_r.mant[16:1]};

  // start and advance requests
  logic raw_start;
  logic raw_adv;
  logic ext_tick;

  assign raw_start = trig_p && to_start;
  assign raw_adv   = trig_p && to_adv;
  assign ext_tick  = pin_rise[mtr_pkg::PIN_EXT];

  logic [mtr_pkg::NUM_EV-1:0] ev;
  logic [31:0]                rd_mux;

  always_comb
  begin
    st_nxt = st_r;
    ev     = '0;
    rd_mux = 32'h00000000;
    if (ce)
    begin
      st_nxt.start    = 1'b0;
      st_nxt.adv      = 1'b0;
      st_nxt.rate_p   = 1'b0;
      st_nxt.bp_out   = 1'b0;
      st_nxt.ring_out = 1'b0;

      // register writes, each channel holds its own copy
      if (wr_ctrl)
        st_nxt.ctrl = wr_data[mtr_pkg::CTRL_W-1:0];
      if (wr_en && (addr == mtr_pkg::OFS_RATE_LO))
        st_nxt.rate[31:0] = wr_data;
      if (wr_en && (addr == mtr_pkg::OFS_RATE_HI))
        st_nxt.rate[mtr_pkg::RATE_W-1:32] = wr_data[mtr_pkg::RATE_W-33:0];
      if (wr_en && (addr == mtr_pkg::OFS_MANT))
        st_nxt.mant = wr_data[16:0];
      if (wr_en && (addr == mtr_pkg::OFS_IRQ_MSK))
        st_nxt.msk = wr_data[mtr_pkg::NUM_EV-1:0];

      // rate generator: prescaler to 200 ns, then step count
      if (rate_en)
      begin
        if (st_r.pre == 2'(mtr_pkg::RATE_STEP_CYC - 1))
        begin
          st_nxt.pre = 2'h0;
          if (st_r.step >= period_m1)
          begin
            st_nxt.step   = '0;
            st_nxt.rate_p = 1'b1;
          end
          else
            st_nxt.step = st_r.step + mtr_pkg::RATE_W'(1);
        end
        else
          st_nxt.pre = st_r.pre + 2'h1;
      end
      else
      begin
        st_nxt.pre  = 2'h0;
        st_nxt.step = '0;
      end

      // external clock: count sample clock edges before starting
      if (raw_start && (clk_src == mtr_pkg::CLK_EXT))
      begin
        st_nxt.lat_pend = 1'b1;
        st_nxt.lat_cnt  = 3'h0;
      end
      else if (st_r.lat_pend && ext_tick)
      begin
        if (st_r.lat_cnt == 3'(mtr_pkg::EXT_LAT_PERIODS - 1))
        begin
          st_nxt.lat_pend = 1'b0;
          st_nxt.start    = 1'b1;
        end
        else
          st_nxt.lat_cnt = st_r.lat_cnt + 3'h1;
      end
      if (raw_start && (clk_src != mtr_pkg::CLK_EXT))
        st_nxt.start = 1'b1;

      // advance qualification, the idle clear and a taken advance override a new event
      if (raw_adv && adv_event)
        st_nxt.adv_lat = 1'b1;

      case (st_r.seq)
        mtr_pkg::MTR_IDLE:
        begin
          st_nxt.adv_lat = 1'b0;
        end
        mtr_pkg::MTR_RUN:
        begin
          if ((adv_event ? (st_r.adv_lat || raw_adv) : (to_adv && trig_l)) &&
              (!adv_sync || seg_end))
          begin
            st_nxt.adv     = 1'b1;
            st_nxt.adv_lat = 1'b0;
            st_nxt.seg     = (st_r.seg >= seg_last) ? 2'h0 : st_r.seg + 2'h1;
          end
        end
        default:
        begin
          st_nxt.seq = mtr_pkg::MTR_IDLE;
        end
      endcase

      // start wins over a pending advance
      if (st_nxt.start)
      begin
        st_nxt.seq     = mtr_pkg::MTR_RUN;
        st_nxt.seg     = 2'h0;
        st_nxt.adv     = 1'b0;
        st_nxt.adv_lat = 1'b0;
        st_nxt.gate    = 1'b1;
      end
      else if (count_done)
      begin
        st_nxt.gate = 1'b0;
        st_nxt.seq  = mtr_pkg::MTR_IDLE;
      end

      // loop-all tracking restarts once the set is complete
      if (loop_all && loop_ev)
        st_nxt.loop_seen = 4'h0;
      else
        st_nxt.loop_seen = loop_acc;

      // backplane and ring drive only inside the chain
      st_nxt.bp_out   = chain_en && bp_p;
      st_nxt.ring_out = chain_en && ring_en && bp_p;

      // phase lock needs a whole waveform cycle after a change
      if (cmd_phase)
      begin
        st_nxt.lock     = 1'b0;
        st_nxt.lock_cnt = 2'h0;
      end
      else if (!st_r.lock && wave_done)
      begin
        if (st_r.lock_cnt == 2'(mtr_pkg::LOCK_MARKS - 1))
        begin
          st_nxt.lock = 1'b1;
          ev[mtr_pkg::EV_LOCK] = 1'b1;
        end
        else
          st_nxt.lock_cnt = st_r.lock_cnt + 2'h1;
      end

      // master clock output figure
      st_nxt.clk_khz = phase_acc_mode ? mtr_pkg::PA_CLK_KHZ : raster_khz;

      // sticky events, a new event beats the write-one clear
      ev[mtr_pkg::EV_START] = st_nxt.start;
      ev[mtr_pkg::EV_ADV]   = st_nxt.adv;
      ev[mtr_pkg::EV_BP]    = st_nxt.bp_out;
      if (wr_en && (addr == mtr_pkg::OFS_IRQ_ST))
        st_nxt.ist = st_r.ist & ~wr_data[mtr_pkg::NUM_EV-1:0];
      st_nxt.ist = st_nxt.ist | ev;
      st_nxt.irq = |(st_nxt.ist & st_nxt.msk);

      // read data valid for the single cycle after the strobe
      case (addr)
        mtr_pkg::OFS_CTRL:    rd_mux = {7'h00, st_r.ctrl};
        mtr_pkg::OFS_RATE_LO: rd_mux = st_r.rate[31:0];
        mtr_pkg::OFS_RATE_HI: rd_mux = {28'h0000000, st_r.rate[mtr_pkg::RATE_W-1:32]};
        mtr_pkg::OFS_MANT:    rd_mux = {15'h0000, st_r.mant};
        mtr_pkg::OFS_STATUS:  rd_mux = {26'h0000000, st_r.lat_pend, st_r.gate,
                                        st_r.lock, st_r.seq == mtr_pkg::MTR_RUN, st_r.seg};
        mtr_pkg::OFS_IRQ_ST:  rd_mux = {28'h0000000, st_r.ist};
        mtr_pkg::OFS_IRQ_MSK: rd_mux = {28'h0000000, st_r.msk};
        default:              rd_mux = 32'h00000000;
      endcase
      st_nxt.rd = rd_en ? rd_mux : 32'h00000000;
    end
  end

  // lock starts set so a lone channel reads as locked
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r         <= '0;
      st_r.ctrl    <= mtr_pkg::CTRL_RST;
      st_r.seq     <= mtr_pkg::MTR_IDLE;
      st_r.lock    <= 1'b1;
      st_r.clk_khz <= mtr_pkg::PA_CLK_KHZ;
    end
    else
      st_r <= st_nxt;
  end

  // outputs straight from the state flops
  assign rd_data       = st_r.rd;
  assign start_trig    = st_r.start;
  assign adv_trig      = st_r.adv;
  assign seg_idx       = st_r.seg;
  assign gate_run      = st_r.gate;
  assign bp_trig_out   = st_r.bp_out;
  assign ring_trig_out = st_r.ring_out;
  assign rate_trig     = st_r.rate_p;
  assign phase_lock    = st_r.lock;
  assign clk_src_sel   = st_r.ctrl[mtr_pkg::F_CLK_SRC +: 2];
  assign sys_clk_ch    = st_r.ctrl[mtr_pkg::F_SYS_CH +: 2];
  assign clk_out_khz   = st_r.clk_khz;
  assign irq           = st_r.irq;
endmodule : mtr_channel
`default_nettype wire

// file: mtr_chain_model.sv
// neighbouring channels on the backplane trigger chain
`default_nettype none
module mtr_chain_model (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // bench fires the previous channel
  input  wire logic fire,
  // backplane lines
  input  wire logic bp_out,
  output logic      bp_in,
  output int        rx_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] hold_r;
  // pulse stretched so the receiving filter sees it
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      hold_r   <= 3'h0;
      rx_count <= 0;
    end
    else
    begin
      hold_r   <= fire ? 3'h4 : hold_r - {2'h0, hold_r != 3'h0};
      rx_count <= rx_count + int'(bp_out);
    end
  assign bp_in = hold_r != 3'h0;
endmodule : mtr_chain_model
`default_nettype wire

// file: mtr_channel_checker.sv
// port assertions for one trigger router channel
`default_nettype none
module mtr_channel_checker (
  // clock, reset, register port
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        ce,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wr_data,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rd_data,
  // results
  input wire logic        start_trig,
  input wire logic        gate_run,
  input wire logic [1:0]  seg_idx,
  input wire logic        count_done,
  input wire logic        bp_trig_out,
  input wire logic        ring_trig_out,
  input wire logic        rate_trig,
  input wire logic        phase_lock,
  input wire logic [1:0]  clk_src_sel,
  input wire logic [16:0] clk_out_khz,
  input wire logic        irq
);
  logic [24:0] ctrl_r;
  logic        cmd_w;
  assign cmd_w = wr_en && ce && addr == mtr_pkg::OFS_CMD;
  // shadow of the control register
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      ctrl_r <= mtr_pkg::CTRL_RST;
    else if (wr_en && ce && addr == mtr_pkg::OFS_CTRL)
      ctrl_r <= wr_data[24:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence msk_off;
    wr_en && ce && addr == mtr_pkg::OFS_IRQ_MSK && wr_data[3:0] == 4'h0;
  endsequence
  sequence cmd_start;
    cmd_w && wr_data[1] && ctrl_r[2:0] == mtr_pkg::TS_CMD && ctrl_r[3] && ctrl_r[6:5] != 2'h1;
  endsequence
  chk_cmd_start: assert property (cmd_start |=> start_trig)
    else $error("start pulse missing after command");
  chk_start_gate: assert property (start_trig |-> gate_run && seg_idx == 2'h0)
    else $error("start without gate or segment zero");
  chk_read_zero: assert property (!$past(rd_en) |-> rd_data == 32'h0)
    else $error("read data outside read slot");
  chk_bp_idle: assert property (!$past(ctrl_r[9]) |-> !bp_trig_out)
    else $error("backplane driven outside chain");
  chk_ring_needs: assert property (ring_trig_out |-> $past(ctrl_r[9] && ctrl_r[10]))
    else $error("ring pulse without ring set up");
  chk_rate_gap: assert property (rate_trig |=> !rate_trig)
    else $error("rate pulses too close");
  chk_pa_fixed: assert property ($past(ctrl_r[11]) |-> clk_out_khz == mtr_pkg::PA_CLK_KHZ)
    else $error("clock figure not fixed");
  chk_clk_sel: assert property ($stable(ctrl_r[6:5]) |-> clk_src_sel == ctrl_r[6:5])
    else $error("clock source select differs");
  chk_lock_drop: assert property (cmd_w && wr_data[2] |=> !phase_lock)
    else $error("lock kept after phase change");
  chk_irq_mask: assert property (msk_off ##1 !(wr_en && addr == mtr_pkg::OFS_IRQ_MSK) |=> !irq)
    else $error("interrupt while fully masked");
endmodule : mtr_channel_checker
bind mtr_channel mtr_channel_checker mtr_channel_checker_i (.ref_clk, .rst_b, .ce, .addr,
  .wr_data, .wr_en, .rd_en, .rd_data, .start_trig, .gate_run, .seg_idx, .count_done,
  .bp_trig_out, .ring_trig_out, .rate_trig, .phase_lock, .clk_src_sel, .clk_out_khz, .irq);
`default_nettype wire

// file: mtr_tb.sv
// self-checking bench for one trigger router channel
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [4:0]  pin = 5'h0;
  logic [3:0]  ev = 4'h0;
  logic        seg_end = 1'b0;
  logic [31:0] rd_data;
  logic        start_trig, adv_trig, gate_run, bp_trig_out, ring_trig_out;
  logic        rate_trig, phase_lock, irq, bp_in;
  logic [1:0]  seg_idx, clk_src_sel, sys_clk_ch;
  logic [16:0] clk_out_khz;
  logic [2:0]  bp_src [5] = '{mtr_pkg::BP_TRACE, mtr_pkg::BP_BURST, mtr_pkg::BP_COUNT,
                              mtr_pkg::BP_WAVE, mtr_pkg::BP_LOOP};
  logic [2:0]  ts [5] = '{mtr_pkg::TS_SYS, mtr_pkg::TS_SYS, mtr_pkg::TS_PIN,
                          mtr_pkg::TS_MASTER, mtr_pkg::TS_PREV};
  int          bad_count = 0;
  int          total_checks = 0;
  int          rx_count, k, w, n;
  int          t [2];
  always #50 ref_clk = ~ref_clk;
  mtr_channel mtr_channel_i (.ref_clk, .rst_b, .ce(1'b1), .addr, .wr_data, .wr_en, .rd_en,
    .rd_data, .sys_trig_pin(pin[0]), .manual_key(pin[1]), .chan_trig_pin(pin[2]),
    .master_trig_in(pin[3]), .bp_trig_in(bp_in), .ext_clk_in(1'b0), .trace_end(ev[0]),
    .burst_done(ev[1]), .count_done(ev[2]), .wave_done(ev[3]), .seg_loop_done(ev),
    .seg_end, .start_trig, .adv_trig, .seg_idx, .gate_run, .bp_trig_out, .ring_trig_out,
    .rate_trig, .phase_lock, .clk_src_sel, .sys_clk_ch, .clk_out_khz, .irq);
  mtr_chain_model mtr_chain_model_i (.ref_clk, .rst_b, .fire(pin[4]), .bp_out(bp_trig_out),
    .bp_in, .rx_count);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge ref_clk);
    wr_en   <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk("rd_data", exp, rd_data);
  endtask : rd
  task automatic eng(input logic [3:0] e, input logic s);
    @(posedge ref_clk);
    ev      <= e;
    seg_end <= s;
    @(posedge ref_clk);
    ev      <= 4'h0;
    seg_end <= 1'b0;
    #1;
  endtask : eng
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // tests need well under a thousand cycles
  initial
  begin
    #400000;
    bad_count++;
    end_of_test();
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(mtr_pkg::OFS_CTRL, 32'(mtr_pkg::CTRL_RST));
    rd(8'h20, 32'h0);
    rd(mtr_pkg::OFS_CMD, 32'h0);
    chk("phase_lock", 1, phase_lock);
    $display("test reset done");
    wr(mtr_pkg::OFS_IRQ_MSK, 32'hF);
    wr(mtr_pkg::OFS_CTRL, 32'h080000B);
    wr(mtr_pkg::OFS_CMD, 32'h2);
    chk("start_trig", 1, start_trig);
    chk("gate_run", 1, gate_run);
    chk("seg_idx", 0, seg_idx);
    rd(mtr_pkg::OFS_IRQ_ST, 32'h1);
    chk("irq", 1, irq);
    wr(mtr_pkg::OFS_IRQ_ST, 32'h1);
    rd(mtr_pkg::OFS_IRQ_ST, 32'h0);
    chk("irq", 0, irq);
    $display("test start done");
    wr(mtr_pkg::OFS_CTRL, 32'h0801013);
    wr(mtr_pkg::OFS_CMD, 32'h2);
    chk("adv_trig", 1, adv_trig);
    chk("seg_idx", 1, seg_idx);
    wr(mtr_pkg::OFS_CMD, 32'h2);
    chk("seg_idx", 0, seg_idx);
    wr(mtr_pkg::OFS_CTRL, 32'h0803013);
    wr(mtr_pkg::OFS_CMD, 32'h2);
    chk("adv_trig", 0, adv_trig);
    eng(4'h0, 1'b1);
    chk("adv_trig", 1, adv_trig);
    chk("seg_idx", 1, seg_idx);
    $display("test advance done");
    for (k = 0; k < 5; k++)
    begin
      wr(mtr_pkg::OFS_CTRL, {15'h1E, bp_src[k], 14'h0});
      eng(4'h1 << k % 4, 1'b0);
      chk("bp_trig_out", 0, bp_trig_out);
      wr(mtr_pkg::OFS_CTRL, {15'h1E, bp_src[k], 14'h600});
      eng(4'h1 << k % 4, 1'b0);
      chk("bp_trig_out", 1, bp_trig_out);
      chk("ring_trig_out", 1, ring_trig_out);
    end
    @(posedge ref_clk) #1;
    chk("rx_count", 5, rx_count);
    $display("test chain done");
    for (k = 0; k < 5; k++)
    begin
      wr(mtr_pkg::OFS_CTRL, 32'h14208 | 32'(ts[k]));
      @(posedge ref_clk) pin[k] <= 1'b1;
      for (w = 0; w < 12 && start_trig !== 1'b1; w++)
        @(posedge ref_clk) #1;
      chk("start_trig", 1, start_trig);
      chk("bp_trig_out", 1, bp_trig_out);
      @(posedge ref_clk) pin[k] <= 1'b0;
    end
    $display("test sources done");
    wr(mtr_pkg::OFS_RATE_LO, 32'h2);
    wr(mtr_pkg::OFS_RATE_HI, 32'h0);
    wr(mtr_pkg::OFS_CTRL, 32'h400002);
    n = 0;
    for (w = 0; w < 40 && n < 2; w++)
    begin
      @(posedge ref_clk) #1;
      if (rate_trig === 1'b1)
      begin
        t[n] = w;
        n++;
      end
    end
    chk("rate period", 4, t[1] - t[0]);
    wr(mtr_pkg::OFS_CTRL, 32'h0);
    $display("test rate done");
    wr(mtr_pkg::OFS_MANT, 32'h4E20);
    wr(mtr_pkg::OFS_CTRL, 32'h1C0);
    @(posedge ref_clk) #1;
    chk("clk_src_sel", 2, clk_src_sel);
    chk("sys_clk_ch", 3, sys_clk_ch);
    chk("clk_out_khz", 32'h9C40, clk_out_khz);
    wr(mtr_pkg::OFS_MANT, 32'hEA60);
    @(posedge ref_clk) #1;
    chk("clk_out_khz", 32'h7530, clk_out_khz);
    wr(mtr_pkg::OFS_CTRL, 32'h800);
    @(posedge ref_clk) #1;
    chk("clk_out_khz", 32'(mtr_pkg::PA_CLK_KHZ), clk_out_khz);
    $display("test clocks done");
    wr(mtr_pkg::OFS_IRQ_MSK, 32'h0);
    wr(mtr_pkg::OFS_IRQ_ST, 32'hF);
    wr(mtr_pkg::OFS_CMD, 32'h4);
    chk("phase_lock", 0, phase_lock);
    eng(4'h8, 1'b0);
    chk("phase_lock", 0, phase_lock);
    eng(4'h8, 1'b0);
    chk("phase_lock", 1, phase_lock);
    rd(mtr_pkg::OFS_IRQ_ST, 32'h8);
    chk("irq", 0, irq);
    $display("test lock done");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
